// file: hdl/sealer_pkg.sv
package sealer_pkg;
	// timebase: one millisecond tick from the 40 MHz clock
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_NS       = 1000000;
	localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
	localparam int MS_W          = 13;
	localparam int HOLD_MS       = 2000;
	localparam int CONFIRM_MS    = 3000;
	localparam int LOCKMSG_MS    = 5000;
	localparam int MANUAL_MS     = 5000;
	localparam int POWERUP_MS    = 4000;
	localparam logic [MS_W-1:0] HOLD_T    = MS_W'(HOLD_MS);
	localparam logic [MS_W-1:0] CONFIRM_T = MS_W'(CONFIRM_MS);
	localparam logic [MS_W-1:0] LOCKMSG_T = MS_W'(LOCKMSG_MS);
	localparam logic [MS_W-1:0] MANUAL_T  = MS_W'(MANUAL_MS);
	localparam logic [MS_W-1:0] POWERUP_T = MS_W'(POWERUP_MS);
	// temperatures in degrees
	localparam int TEMP_W = 9;
	localparam logic [TEMP_W-1:0] START_MIN = 9'h014;
	localparam logic [TEMP_W-1:0] START_MAX = 9'h12c;
	localparam logic [TEMP_W-1:0] LIMIT_DEF = 9'h12c;
	// correction factor in percent
	localparam logic [7:0] CORR_MIN = 8'h32;
	localparam logic [7:0] CORR_MAX = 8'hc8;
	localparam logic [7:0] CORR_DEF = 8'h64;
	localparam logic [MS_W-1:0] SEAL_DEF = 13'h00c8;
	// brightness index: 0=25% 1=50% 2=75% 3=100%
	localparam logic [1:0] BRIGHT_DEF = 2'h2;
	localparam logic [1:0] BRIGHT_MAX = 2'h3;
	// register map
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LIMIT  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CORR   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SEAL   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_FAULT  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
	localparam int CTRL_W         = 3;
	localparam int CTRL_TIMER_BIT = 0;
	localparam int CTRL_INV_BIT   = 1;
	localparam int CTRL_OLD_BIT   = 2;
	localparam int LIM_LSB        = 16;
	localparam logic [CTRL_W-1:0] CTRL_DEF = 3'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// synchronised inputs
	localparam int NIN = 8;
	localparam int K_ENTER = 0;
	localparam int K_UP    = 1;
	localparam int K_DOWN  = 2;
	localparam int K_MENU  = 3;
	localparam int K_RESET = 4;
	localparam int K_EXT   = 5;
	localparam int K_START = 6;
	localparam int K_UV    = 7;
	typedef enum logic [1:0] {F_NONE, F_OPEN, F_CLOSED} fault_t;
	typedef enum logic [1:0] {H_IDLE, H_AUTO, H_MANUAL, H_DONE} heat_t;
	typedef enum logic [2:0] {M_POWERUP, M_HOME, M_AUTO, M_MANUAL,
		M_CONFIG} menu_t;
	typedef enum logic [3:0] {D_POWERUP, D_HOME, D_AUTO, D_MANUAL,
		D_CONFIG, D_LOCK_ON, D_LOCK_OFF, D_LOCKED, D_STANDBY} disp_t;
endpackage : sealer_pkg

// file: hdl/sealer_supervision_control.sv
// What this block does
// - auto cycle step only with time control on; each enter starts one cycle
// - in auto and manual steps up and down adjust the correction factor
// - manual heating lasts only while enter is held
// - manual heating is cut off after 5 seconds even with enter held
// - each heating start samples actual temperature against the start limit
// - too hot at start: heating command ignored and an alarm raised
// - start limit clamped to the configured maximum or range limit
// - menu held 2.0 s during power-up message toggles the lock
// - lock confirmation shown 3.0 s, then home position
// - opening the locked configuration menu shows lock message 5.0 s
// - locked configuration stays readable but every change is refused
// - lock survives power cycles, shipped unlocked
// - home position up/down steps brightness 25/50/75/100, default 75
// - undervoltage: standby, no sealing, no measuring, standby shown
// - voltage back: leave standby, main menu, normal operation
// - old firmware: undervoltage switches relay, analog holds last value
// - new firmware: relay unchanged, analog output forced to zero
// - open for calibration/config faults, closes on start in that state
// - closed for signal, step, frequency and internal fault classes
// - inverted relay polarity inverts every contact state
// - alarm cleared by reset key, external reset or power cycle
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sealer_supervision_control #(
	parameter int TICK_DIV = sealer_pkg::TICK_CYC
) (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [sealer_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [sealer_pkg::ADDR_W-1:0] araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	input  wire logic                          enter_key,
	input  wire logic                          up_key,
	input  wire logic                          down_key,
	input  wire logic                          menu_key,
	input  wire logic                          reset_key,
	input  wire logic                          ext_reset,
	input  wire logic                          start_in,
	input  wire logic                          undervoltage,
	input  wire logic [sealer_pkg::TEMP_W-1:0] actual_temp,
	input  wire logic                          lock_stored,
	output logic                               heat_cmd,
	output logic                               measure_en,
	output logic                               alarm_relay,
	output logic [sealer_pkg::TEMP_W-1:0]      analog_out,
	output sealer_pkg::disp_t                  display_code,
	output logic [1:0]                         brightness,
	output logic                               lock_state
);
	import sealer_pkg::*;

	// ****************************************
	// input synchronisers and timebase
	// ****************************************
	logic [NIN-1:0] sync1_reg;
	logic [NIN-1:0] sync2_reg;
	logic [NIN-1:0] prev_reg;
	logic [15:0]    div_reg;
	wire  [NIN-1:0] raw = {undervoltage, start_in, ext_reset, reset_key,
		menu_key, down_key, up_key, enter_key};
	wire  [NIN-1:0] lvl  = sync2_reg;
	wire  [NIN-1:0] rise = sync2_reg & ~prev_reg;
	wire            tick = div_reg == 16'(TICK_DIV - 1);
	wire            standby = lvl[K_UV];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
		end
		else
		begin
			sync1_reg <= raw;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || tick)
			div_reg <= 16'h0;
		else
			div_reg <= div_reg + 16'h1;
	end

	// ****************************************
	// register bus slave
	// ****************************************
	logic [CTRL_W-1:0] ctrl_reg;
	logic [TEMP_W-1:0] start_set_reg;
	logic [TEMP_W-1:0] limit_reg;
	logic [7:0]        corr_reg;
	logic [MS_W-1:0]   seal_reg;
	fault_t            fault_reg;
	logic              started_reg;
	logic              lock_reg;
	logic              relay_reg;
	logic [1:0]        bright_reg;
	disp_t             disp_reg;
	heat_t             heat_reg;
	logic [ADDR_W-1:0] waddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              aw_have_reg;
	logic              w_have_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [1:0]        rresp_reg;
	logic [31:0]       rdata_reg;

	function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a);
		if (a == OFF_CTRL)
			return {29'h0, ctrl_reg};
		else if (a == OFF_LIMIT)
			return {7'h0, limit_reg, 7'h0, start_set_reg};
		else if (a == OFF_CORR)
			return {24'h0, corr_reg};
		else if (a == OFF_SEAL)
			return {19'h0, seal_reg};
		else if (a == OFF_FAULT)
			return {29'h0, started_reg, fault_reg};
		else if (a == OFF_STATUS)
			return {20'h0, disp_reg, bright_reg, fault_reg, relay_reg,
				lock_reg, standby, heat_reg != H_IDLE};
		else
			return 32'h0;
	endfunction : reg_word

	wire        wr_go   = aw_have_reg && w_have_reg && !bvalid_reg;
	wire        hit_cfg = waddr_reg == OFF_CTRL || waddr_reg == OFF_LIMIT;
	wire        hit_any = hit_cfg || waddr_reg == OFF_CORR
		|| waddr_reg == OFF_SEAL || waddr_reg == OFF_FAULT;
	// a locked configuration refuses writes with an error answer
	wire        wr_ok   = hit_any && !(hit_cfg && lock_reg);
	wire        wr_en   = wr_go && wr_ok;
	wire [31:0] wmask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	wire [31:0] wmerged = (reg_word(waddr_reg) & ~wmask)
		| (wdata_reg & wmask);
	wire        wr_ctrl  = wr_en && waddr_reg == OFF_CTRL;
	wire        wr_limit = wr_en && waddr_reg == OFF_LIMIT;
	wire        wr_corr  = wr_en && waddr_reg == OFF_CORR;
	wire        wr_seal  = wr_en && waddr_reg == OFF_SEAL;
	wire        wr_fault = wr_en && waddr_reg == OFF_FAULT;
	wire        aw_hs    = awvalid && awready_reg;
	wire        w_hs     = wvalid && wready_reg;
	wire        ar_hs    = arvalid && arready_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			waddr_reg   <= '0;
			wdata_reg   <= 32'h0;
			wstrb_reg   <= 4'h0;
		end
		else
		begin
			if (aw_hs)
			begin
				aw_have_reg <= 1'b1;
				awready_reg <= 1'b0;
				waddr_reg   <= awaddr;
			end
			if (w_hs)
			begin
				w_have_reg <= 1'b1;
				wready_reg <= 1'b0;
				wdata_reg  <= wdata;
				wstrb_reg  <= wstrb;
			end
			if (wr_go)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_reg && bready)
			begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= 32'h0;
		end
		else if (ar_hs)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= reg_word(araddr);
			rresp_reg   <= (araddr == OFF_CTRL || araddr == OFF_LIMIT
				|| araddr == OFF_CORR || araddr == OFF_SEAL
				|| araddr == OFF_FAULT || araddr == OFF_STATUS)
				? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && rready)
		begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg      <= CTRL_DEF;
			start_set_reg <= START_MAX;
			limit_reg     <= LIMIT_DEF;
			seal_reg      <= SEAL_DEF;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= wmerged[CTRL_W-1:0];
			if (wr_limit)
			begin
				start_set_reg <= wmerged[TEMP_W-1:0];
				limit_reg     <= wmerged[LIM_LSB +: TEMP_W];
			end
			if (wr_seal)
				seal_reg <= wmerged[MS_W-1:0];
		end
	end

	wire timer_on = ctrl_reg[CTRL_TIMER_BIT];
	wire relay_inv = ctrl_reg[CTRL_INV_BIT];
	wire fw_old = ctrl_reg[CTRL_OLD_BIT];

	// ****************************************
	// operator menu, lock and messages
	// ****************************************
	menu_t           menu_reg;
	menu_t           menu_nav;
	menu_t           menu_next;
	logic [MS_W-1:0] pwr_cnt_reg;
	logic [MS_W-1:0] hold_cnt_reg;
	logic [MS_W-1:0] ovl_cnt_reg;
	logic [MS_W-1:0] ovl_len_reg;
	logic            ovl_on_reg;
	disp_t           ovl_reg;
	logic            loaded_reg;

	wire menu_press = rise[K_MENU] && menu_reg != M_POWERUP;
	wire pwr_end = menu_reg == M_POWERUP && tick
		&& pwr_cnt_reg == POWERUP_T - 13'h1;
	wire lock_toggle = menu_reg == M_POWERUP && lvl[K_MENU] && tick
		&& hold_cnt_reg == HOLD_T - 13'h1;
	wire locked_open = menu_press && menu_reg == M_MANUAL && lock_reg;
	wire ovl_end = ovl_on_reg && tick
		&& ovl_cnt_reg == ovl_len_reg - 13'h1;
	assign menu_nav = menu_reg == M_HOME ? (timer_on ? M_AUTO : M_MANUAL)
		: menu_reg == M_AUTO ? M_MANUAL
		: menu_reg == M_MANUAL ? M_CONFIG : M_HOME;
	assign menu_next = standby ? M_HOME
		: (lock_toggle || pwr_end) ? M_HOME
		: (menu_reg == M_AUTO && !timer_on) ? M_HOME
		: menu_press ? menu_nav : menu_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			menu_reg     <= M_POWERUP;
			pwr_cnt_reg  <= '0;
			hold_cnt_reg <= '0;
		end
		else
		begin
			menu_reg <= menu_next;
			if (tick && menu_reg == M_POWERUP)
				pwr_cnt_reg <= pwr_cnt_reg + 13'h1;
			if (!lvl[K_MENU])
				hold_cnt_reg <= '0;
			else if (tick && hold_cnt_reg != HOLD_T)
				hold_cnt_reg <= hold_cnt_reg + 13'h1;
		end
	end

	// nonvolatile lock value is taken once, just after reset release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lock_reg   <= 1'b0;
			loaded_reg <= 1'b0;
		end
		else if (!loaded_reg)
		begin
			lock_reg   <= lock_stored;
			loaded_reg <= 1'b1;
		end
		else if (lock_toggle)
			lock_reg <= !lock_reg;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ovl_on_reg  <= 1'b0;
			ovl_reg     <= D_HOME;
			ovl_cnt_reg <= '0;
			ovl_len_reg <= CONFIRM_T;
		end
		else if (lock_toggle)
		begin
			ovl_on_reg  <= 1'b1;
			ovl_reg     <= lock_reg ? D_LOCK_OFF : D_LOCK_ON;
			ovl_cnt_reg <= '0;
			ovl_len_reg <= CONFIRM_T;
		end
		else if (locked_open)
		begin
			ovl_on_reg  <= 1'b1;
			ovl_reg     <= D_LOCKED;
			ovl_cnt_reg <= '0;
			ovl_len_reg <= LOCKMSG_T;
		end
		else if (ovl_end)
			ovl_on_reg <= 1'b0;
		else if (tick && ovl_on_reg)
			ovl_cnt_reg <= ovl_cnt_reg + 13'h1;
	end

	// correction factor keys only act inside the two impulse steps
	wire in_step = menu_reg == M_AUTO || menu_reg == M_MANUAL;
	wire at_home = menu_reg == M_HOME && !ovl_on_reg && !standby;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			corr_reg   <= CORR_DEF;
			bright_reg <= BRIGHT_DEF;
		end
		else
		begin
			if (wr_corr)
				corr_reg <= wmerged[7:0];
			else if (in_step && rise[K_UP] && corr_reg < CORR_MAX)
				corr_reg <= corr_reg + 8'h1;
			else if (in_step && rise[K_DOWN] && corr_reg > CORR_MIN)
				corr_reg <= corr_reg - 8'h1;
			if (at_home && rise[K_UP] && bright_reg != BRIGHT_MAX)
				bright_reg <= bright_reg + 2'h1;
			else if (at_home && rise[K_DOWN] && bright_reg != 2'h0)
				bright_reg <= bright_reg - 2'h1;
		end
	end

	// ****************************************
	// heating sequencer and start check
	// ****************************************
	logic [MS_W-1:0]   heat_cnt_reg;
	wire  [MS_W-1:0]   heat_cnt_inc = heat_cnt_reg + 13'h1;
	wire  [TEMP_W-1:0] upper = limit_reg < START_MAX ? limit_reg
		: START_MAX;
	wire  [TEMP_W-1:0] start_eff = start_set_reg < START_MIN ? START_MIN
		: start_set_reg > upper ? upper : start_set_reg;
	wire start_auto = timer_on && ((rise[K_ENTER] && menu_reg == M_AUTO)
		|| rise[K_START]);
	wire start_man = rise[K_ENTER] && menu_reg == M_MANUAL;
	wire heat_go = heat_reg == H_IDLE && !standby
		&& (start_auto || start_man);
	// the limit is judged on the sample taken at the start edge
	wire too_hot = actual_temp > start_eff;
	wire hot_alarm = heat_go && too_hot;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			heat_reg     <= H_IDLE;
			heat_cnt_reg <= '0;
		end
		else
		begin
			case (heat_reg)
				H_IDLE:
					if (heat_go && !too_hot)
					begin
						heat_reg     <= start_man ? H_MANUAL : H_AUTO;
						heat_cnt_reg <= '0;
					end
				H_AUTO:
					if (standby || (tick && heat_cnt_inc >= seal_reg))
						heat_reg <= H_IDLE;
					else if (tick)
						heat_cnt_reg <= heat_cnt_inc;
				H_MANUAL:
					if (standby || !lvl[K_ENTER])
						heat_reg <= H_IDLE;
					else if (tick && heat_cnt_inc == MANUAL_T)
						heat_reg <= H_DONE;
					else if (tick)
						heat_cnt_reg <= heat_cnt_inc;
				H_DONE:
					if (!lvl[K_ENTER])
						heat_reg <= H_IDLE;
				default:
					heat_reg <= H_IDLE;
			endcase
		end
	end

	// ****************************************
	// alarm state and outputs
	// ****************************************
	wire alarm_clr = rise[K_RESET] || rise[K_EXT];
	wire relay_closed = fault_reg == F_CLOSED
		|| (fault_reg == F_OPEN && started_reg)
		|| (standby && fw_old);
	wire [TEMP_W-1:0] analog_next = !standby ? actual_temp
		: fw_old ? analog_out : '0;
	wire disp_t disp_next = standby ? D_STANDBY
		: ovl_on_reg ? ovl_reg
		: menu_reg == M_POWERUP ? D_POWERUP
		: menu_reg == M_AUTO ? D_AUTO
		: menu_reg == M_MANUAL ? D_MANUAL
		: menu_reg == M_CONFIG ? D_CONFIG : D_HOME;

	// a new fault in the clearing cycle wins over the clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fault_reg   <= F_NONE;
			started_reg <= 1'b0;
		end
		else if (hot_alarm)
			fault_reg <= F_CLOSED;
		else if (wr_fault)
		begin
			fault_reg   <= fault_t'(wmerged[1:0]);
			started_reg <= 1'b0;
		end
		else if (alarm_clr)
		begin
			fault_reg   <= F_NONE;
			started_reg <= 1'b0;
		end
		else if (fault_reg == F_OPEN && rise[K_START])
			started_reg <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			relay_reg    <= 1'b0;
			analog_out   <= '0;
			heat_cmd     <= 1'b0;
			measure_en   <= 1'b0;
			disp_reg     <= D_POWERUP;
		end
		else
		begin
			relay_reg  <= relay_closed ^ relay_inv;
			analog_out <= analog_next;
			heat_cmd   <= heat_reg == H_AUTO || heat_reg == H_MANUAL;
			measure_en <= !standby;
			disp_reg   <= disp_next;
		end
	end

	assign awready      = awready_reg;
	assign wready       = wready_reg;
	assign bvalid       = bvalid_reg;
	assign bresp        = bresp_reg;
	assign arready      = arready_reg;
	assign rvalid       = rvalid_reg;
	assign rresp        = rresp_reg;
	assign rdata        = rdata_reg;
	assign alarm_relay  = relay_reg;
	assign display_code = disp_reg;
	assign brightness   = bright_reg;
	assign lock_state   = lock_reg;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_auto_needs_timer: assert property (
		menu_reg == M_AUTO && !timer_on |=> menu_reg != M_AUTO)
		else $error("auto step without timer");
	a_manual_release: assert property (
		heat_reg == H_MANUAL && !lvl[K_ENTER] |=> heat_reg == H_IDLE)
		else $error("manual heat kept after release");
	a_manual_cutoff: assert property (
		heat_reg == H_MANUAL && lvl[K_ENTER] && !standby && tick
		&& heat_cnt_inc == MANUAL_T |=> heat_reg == H_DONE)
		else $error("no manual cutoff");
	a_hot_start: assert property (
		hot_alarm |=> heat_reg == H_IDLE && fault_reg == F_CLOSED)
		else $error("hot start not blocked");
	a_start_clamp: assert property (
		start_eff >= START_MIN && start_eff <= upper)
		else $error("start limit not clamped");
	a_lock_refuse: assert property (
		wr_go && hit_cfg && lock_reg |=> bresp_reg == RESP_SLVERR
		&& $stable(ctrl_reg) && $stable(limit_reg))
		else $error("locked write taken");
	// measuring stops one edge after standby, heating one edge later
	a_standby_idle: assert property (
		standby |=> !measure_en ##1 !heat_cmd)
		else $error("heating in standby");
	a_analog_zero: assert property (
		standby && !fw_old |=> analog_out == '0)
		else $error("analog not zero");
	a_relay_polar: assert property (
		##1 relay_reg == $past(relay_closed ^ relay_inv))
		else $error("relay polarity wrong");
	a_bright_step: assert property (
		at_home && rise[K_UP] && bright_reg != BRIGHT_MAX
		|=> bright_reg == $past(bright_reg) + 2'h1)
		else $error("no bright step");
	a_alarm_clear: assert property (
		alarm_clr && !hot_alarm && !wr_fault |=> fault_reg == F_NONE)
		else $error("alarm not cleared");

	c_manual_cut: cover property (heat_reg == H_MANUAL
		##1 heat_reg == H_DONE);
	c_hot_block: cover property (hot_alarm);
	c_lock_toggle: cover property (lock_toggle);
	c_standby: cover property (standby ##1 !standby);
endmodule : sealer_supervision_control
`default_nettype wire

// file: test/operator_panel.sv
`timescale 1ns/1ps
`default_nettype none
module operator_panel (
	input  wire logic  aclk,
	input  wire logic  aresetn,
	input  wire logic  lock_state,
	output logic [7:0] keys,
	output logic       lock_stored
);
	logic up_reg;
	initial keys = 8'h00;
	initial up_reg = 1'b0;
	// nonvolatile copy frozen from reset entry until one edge after release,
	// so the lock outlives a reset
	initial lock_stored = 1'b0;
	always @(posedge aclk)
	begin
		up_reg <= aresetn;
		if (aresetn && up_reg)
			lock_stored <= lock_state;
	end
	task automatic hold(input int k, input int n);
		keys[k] <= 1'b1;
		repeat (n) @(posedge aclk);
		keys[k] <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask : hold
endmodule : operator_panel
`default_nettype wire

// file: test/sealer_supervision_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sealer_supervision_control_tb;
	import sealer_pkg::*;
	localparam int T = 2;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, heat_cmd, measure_en;
	logic alarm_relay, lock_state, lock_stored;
	logic [7:0] awaddr, araddr, keys;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, brightness, r;
	logic [8:0] analog_out, actual_temp;
	disp_t display_code;
	int n_fail, n_compared;
	sealer_supervision_control #(.TICK_DIV(T)) DUT (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.enter_key(keys[K_ENTER]), .up_key(keys[K_UP]),
		.down_key(keys[K_DOWN]), .menu_key(keys[K_MENU]),
		.reset_key(keys[K_RESET]), .ext_reset(keys[K_EXT]),
		.start_in(keys[K_START]), .undervoltage(keys[K_UV]),
		.actual_temp(actual_temp), .lock_stored(lock_stored),
		.heat_cmd(heat_cmd), .measure_en(measure_en),
		.alarm_relay(alarm_relay), .analog_out(analog_out),
		.display_code(display_code), .brightness(brightness),
		.lock_state(lock_state));
	operator_panel P (.aclk(aclk), .aresetn(aresetn),
		.lock_state(lock_state), .keys(keys), .lock_stored(lock_stored));
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic chk(input string s, input logic [31:0] v, e);
		n_compared++;
		if (v !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", s, e, v);
		end
	endtask : chk
	// slave outputs read right after the edge still hold pre-edge values;
	// bready and rready stay high all run, so calls may follow back to back
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			r = bresp;
		end while (bvalid !== 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			d = rdata;
			r = rresp;
		end while (rvalid !== 1'b1);
	endtask : rd
	task automatic close_out();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic t_lock();
		chk("bright", brightness, 32'h2);
		chk("lock", lock_state, 32'h0);
		// trial start limit 80: half of a 160 degree seal temperature
		wr(OFF_LIMIT, 32'h012c_0050);
		wr(OFF_CTRL, 32'h3);
		cyc(3);
		chk("inv", alarm_relay, 32'h1);
		wr(OFF_CTRL, 32'h1);
		P.hold(K_MENU, HOLD_MS * T + 40);
		chk("lock", lock_state, 32'h1);
		chk("disp", display_code, 32'(D_LOCK_ON));
		cyc(CONFIRM_MS * T);
		chk("disp", display_code, 32'(D_HOME));
		wr(OFF_CTRL, 32'h3);
		chk("resp", r, 32'(RESP_SLVERR));
		rd(OFF_CTRL);
		chk("ctrl", d, 32'h1);
		rd(8'h18);
		chk("resp", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
	endtask : t_lock
	task automatic t_heat();
		P.hold(K_MENU, 4);
		chk("disp", display_code, 32'(D_AUTO));
		P.hold(K_UP, 4);
		rd(OFF_CORR);
		chk("corr", d, 32'h65);
		P.hold(K_ENTER, 4);
		chk("auto", heat_cmd, 32'h1);
		cyc(SEAL_DEF * T);
		chk("auto", heat_cmd, 32'h0);
		P.hold(K_MENU, 4);
		P.keys[K_ENTER] <= 1'b1;
		cyc(10);
		chk("man", heat_cmd, 32'h1);
		cyc(MANUAL_MS * T + 40);
		chk("cut", heat_cmd, 32'h0);
		P.keys[K_ENTER] <= 1'b0;
		cyc(10);
		P.hold(K_ENTER, 100);
		chk("man", heat_cmd, 32'h0);
		P.keys[K_ENTER] <= 1'b1;
		cyc(MANUAL_MS * T - 2 * T);
		chk("restart", heat_cmd, 32'h1);
		P.keys[K_ENTER] <= 1'b0;
		cyc(10);
		P.hold(K_MENU, 4);
		chk("disp", display_code, 32'(D_LOCKED));
		cyc(LOCKMSG_MS * T);
		chk("disp", display_code, 32'(D_CONFIG));
		P.hold(K_MENU, 4);
	endtask : t_heat
	task automatic t_bright();
		P.hold(K_UP, 4);
		P.hold(K_UP, 4);
		chk("bright", brightness, 32'h3);
		repeat (4) P.hold(K_DOWN, 4);
		chk("bright", brightness, 32'h0);
	endtask : t_bright
	task automatic t_alarm();
		// one degree above the start limit of 80
		actual_temp <= 9'h051;
		P.hold(K_START, 4);
		chk("heat", heat_cmd, 32'h0);
		chk("relay", alarm_relay, 32'h1);
		P.hold(K_RESET, 4);
		chk("relay", alarm_relay, 32'h0);
		actual_temp <= 9'h050;
		wr(OFF_FAULT, 32'h1);
		cyc(3);
		chk("relay", alarm_relay, 32'h0);
		P.hold(K_START, 4);
		chk("relay", alarm_relay, 32'h1);
		P.hold(K_EXT, 4);
		chk("relay", alarm_relay, 32'h0);
		cyc(SEAL_DEF * T);
	endtask : t_alarm
	task automatic t_uv();
		chk("ana", analog_out, 32'h50);
		P.keys[K_UV] <= 1'b1;
		cyc(10);
		chk("meas", measure_en, 32'h0);
		chk("disp", display_code, 32'(D_STANDBY));
		chk("ana", analog_out, 32'h0);
		chk("relay", alarm_relay, 32'h0);
		P.keys[K_UV] <= 1'b0;
		cyc(10);
		chk("meas", measure_en, 32'h1);
		chk("disp", display_code, 32'(D_HOME));
	endtask : t_uv
	// mid-run power cycle: lock kept, toggled off, then old firmware standby
	task automatic t_power();
		aresetn <= 1'b0;
		cyc(5);
		aresetn <= 1'b1;
		cyc(2);
		chk("lock", lock_state, 32'h1);
		chk("disp", display_code, 32'(D_POWERUP));
		P.hold(K_MENU, HOLD_MS * T + 40);
		chk("lock", lock_state, 32'h0);
		chk("disp", display_code, 32'(D_LOCK_OFF));
		wr(OFF_CTRL, 32'h4);
		chk("resp", r, 32'(RESP_OKAY));
		cyc(3);
		P.keys[K_UV] <= 1'b1;
		cyc(10);
		actual_temp <= 9'h070;
		cyc(4);
		chk("ana", analog_out, 32'h50);
		chk("relay", alarm_relay, 32'h1);
		P.keys[K_UV] <= 1'b0;
		actual_temp <= 9'h050;
		cyc(10);
		chk("relay", alarm_relay, 32'h0);
	endtask : t_power
	initial
	begin
		{aresetn, awvalid, wvalid, arvalid} = 4'h0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		actual_temp = 9'h050;
		n_fail = 0;
		n_compared = 0;
		cyc(5);
		aresetn <= 1'b1;
		cyc(1);
		t_lock();
		t_heat();
		t_bright();
		t_alarm();
		t_uv();
		t_power();
		close_out();
	end
	initial
	begin
		cyc(70000);
		n_fail++;
		close_out();
	end
endmodule : sealer_supervision_control_tb
`default_nettype wire
